// ==== pwmfe_top.sv ====
// Purpose: Time base, half-cycle duty comparators and dead-time pairs.
// Assumes: APB3 master; one instruction cycle is two pclk cycles.
// Notes: Duty values take effect at once; no buffering or fault logic.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module pwmfe_top
#(
   parameter int ADDR_W = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [pwmfe_pkg::PAIRS-1:0] high_side_out,
   output logic [pwmfe_pkg::PAIRS-1:0] low_side_out,
   output logic [14:0] time_base_count,
   output logic count_direction
);
   typedef struct packed {
      logic en;
      logic center;
      logic [1:0] tb_presc;
      logic [3:0] pair_mode_sel;
      logic [14:0] period_reg;
      logic [pwmfe_pkg::PAIRS-1:0][15:0] duty_cycle_reg;
      logic [15:0] dead_time_ctrl_one;
      logic [7:0] dead_time_ctrl_two;
      logic phase;
      logic [5:0] presc_cnt;
      logic [14:0] count;
      logic dir;
      logic [pwmfe_pkg::PAIRS-1:0] cmp;
      logic [31:0] rdata;
   } pwmfe_state_type;

   pwmfe_state_type s;
   pwmfe_state_type next_s;
   logic [7:0] addr;
   logic mapped;
   logic setup;
   logic access;
   logic [5:0] presc_max;
   logic tb_tick;
   logic at_start;
   logic [31:0] read_word;
   logic [1:0] ps_a;
   logic [1:0] ps_b;
   logic [5:0] cnt_a;
   logic [5:0] cnt_b;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode. Misaligned or unlisted addresses answer with pslverr.
   assign addr = 8'(paddr);
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   always_comb
   begin
      mapped = 1'b1;
      read_word = 32'h0000_0000;
      case (addr)
         pwmfe_pkg::ADDR_CTRL:
         begin
            read_word[pwmfe_pkg::CTRL_EN_BIT] = s.en;
            read_word[pwmfe_pkg::CTRL_CENTER_BIT] = s.center;
            read_word[pwmfe_pkg::CTRL_TBPS_LSB +: 2] = s.tb_presc;
            read_word[pwmfe_pkg::CTRL_PAIR_MODE_SEL_LSB +: 4] = s.pair_mode_sel;
         end
         pwmfe_pkg::ADDR_PERIOD:
            read_word[14:0] = s.period_reg;
         pwmfe_pkg::ADDR_DT_ONE:
            read_word[15:0] = s.dead_time_ctrl_one;
         pwmfe_pkg::ADDR_DT_TWO:
            read_word[7:0] = s.dead_time_ctrl_two;
         pwmfe_pkg::ADDR_STATUS:
         begin
            read_word[14:0] = s.count;
            read_word[pwmfe_pkg::ST_DIR_BIT] = s.dir;
            read_word[pwmfe_pkg::ST_HIGH_LSB +: 4] = high_side_out;
            read_word[pwmfe_pkg::ST_LOW_LSB +: 4] = low_side_out;
         end
         default:
         begin
            mapped = 1'b0;
            for (int i = 0; i < pwmfe_pkg::PAIRS; i++)
            begin
               if (addr == pwmfe_pkg::ADDR_DUTY0 + 8'(4 * i))
               begin
                  mapped = 1'b1;
                  read_word[15:0] = s.duty_cycle_reg[i];
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Time base. The prescaler counts instruction cycles; the phase bit
   // marks the half of each instruction cycle.
   always_comb
   begin
      case (s.tb_presc)
         pwmfe_pkg::TBPS_1: presc_max = 6'h00;
         pwmfe_pkg::TBPS_4: presc_max = pwmfe_pkg::PRESC_MAX_4;
         pwmfe_pkg::TBPS_16: presc_max = pwmfe_pkg::PRESC_MAX_16;
         default: presc_max = pwmfe_pkg::PRESC_MAX_64;
      endcase
   end

   assign tb_tick = s.phase && (s.presc_cnt == presc_max);
   assign at_start = (s.count == 15'h0000) && !s.phase &&
                     (s.presc_cnt == 6'h00);

   // Half-cycle position of an edge within the matching count.
   function automatic logic edge_pos(input pwmfe_state_type st,
                                     input logic [5:0] pmax,
                                     input logic d0);
      logic [5:0] half;
      half = 6'((pmax >> 1) + 6'h01);
      if (st.tb_presc == pwmfe_pkg::TBPS_1)
         edge_pos = (st.phase == d0);
      else
         edge_pos = !st.phase &&
                    (st.presc_cnt == (d0 ? half : 6'h00));
   endfunction

   always_comb
   begin
      logic hit;
      hit = 1'b0;
      next_s = s;
      if (s.en)
      begin
         next_s.phase = !s.phase;
         if (s.phase)
            next_s.presc_cnt = (s.presc_cnt == presc_max) ? 6'h00 :
                               s.presc_cnt + 6'h01;
         if (tb_tick && !s.center)
         begin
            next_s.count = (s.count >= s.period_reg) ? 15'h0000 :
                           s.count + 15'h0001;
         end
         else if (tb_tick)
         begin
            // Up/down counting takes two sweeps per period.
            if (!s.dir)
            begin
               if (s.count >= s.period_reg)
               begin
                  next_s.dir = (s.period_reg != 15'h0000);
                  next_s.count = (s.period_reg == 15'h0000) ? 15'h0000 :
                                 s.count - 15'h0001;
               end
               else
                  next_s.count = s.count + 15'h0001;
            end
            else
            begin
               next_s.count = s.count - 15'h0001;
               if (s.count == 15'h0001)
                  next_s.dir = 1'b0;
            end
         end
      end
      else
      begin
         next_s.phase = 1'b0;
         next_s.presc_cnt = 6'h00;
         next_s.count = 15'h0000;
         next_s.dir = 1'b0;
      end

      // Duty comparators, one per generator.
      for (int i = 0; i < pwmfe_pkg::PAIRS; i++)
      begin
         hit = (s.duty_cycle_reg[i][15:1] == s.count) &&
               edge_pos(s, presc_max, s.duty_cycle_reg[i][0]);
         if (!s.en || s.duty_cycle_reg[i] == 16'h0000)
            next_s.cmp[i] = 1'b0;
         else if (s.duty_cycle_reg[i][15:1] > s.period_reg)
            next_s.cmp[i] = 1'b1;
         else if (s.center)
         begin
            if (hit)
               next_s.cmp[i] = s.dir;
         end
         else if (hit)
            next_s.cmp[i] = 1'b0;
         else if (at_start)
            next_s.cmp[i] = 1'b1;
      end

      // Register access; read data is captured in the setup cycle.
      if (setup)
         next_s.rdata = read_word;
      if (access && pwrite)
      begin
         case (addr)
            pwmfe_pkg::ADDR_CTRL:
            begin
               next_s.en = pwdata[pwmfe_pkg::CTRL_EN_BIT];
               next_s.center = pwdata[pwmfe_pkg::CTRL_CENTER_BIT];
               next_s.tb_presc = pwdata[pwmfe_pkg::CTRL_TBPS_LSB +: 2];
               next_s.pair_mode_sel = pwdata[pwmfe_pkg::CTRL_PAIR_MODE_SEL_LSB +: 4];
            end
            pwmfe_pkg::ADDR_PERIOD:
               next_s.period_reg = pwdata[14:0];
            pwmfe_pkg::ADDR_DT_ONE:
               next_s.dead_time_ctrl_one = pwdata[15:0];
            pwmfe_pkg::ADDR_DT_TWO:
               next_s.dead_time_ctrl_two = pwdata[7:0];
            default:
            begin
               for (int i = 0; i < pwmfe_pkg::PAIRS; i++)
               begin
                  if (addr == pwmfe_pkg::ADDR_DUTY0 + 8'(4 * i))
                     next_s.duty_cycle_reg[i] = pwdata[15:0];
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '0;
         s.pair_mode_sel <= pwmfe_pkg::PAIR_MODE_SEL_RST;
         s.period_reg <= pwmfe_pkg::PERIOD_RST;
         s.duty_cycle_reg <= {pwmfe_pkg::PAIRS{pwmfe_pkg::DUTY_RST}};
         s.dead_time_ctrl_one <= pwmfe_pkg::DT1_RST;
         s.dead_time_ctrl_two <= pwmfe_pkg::DT2_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Dead-time units and the per-pair generators.
   assign ps_a = s.dead_time_ctrl_one[pwmfe_pkg::DT1_A_PS_LSB +: 2];
   assign ps_b = s.dead_time_ctrl_one[pwmfe_pkg::DT1_B_PS_LSB +: 2];
   assign cnt_a = s.dead_time_ctrl_one[pwmfe_pkg::DT1_A_CNT_LSB +: 6];
   assign cnt_b = s.dead_time_ctrl_one[pwmfe_pkg::DT1_B_CNT_LSB +: 6];

   generate
      for (genvar g = 0; g < pwmfe_pkg::PAIRS; g++)
      begin : pair
         logic sel_act;
         logic sel_inact;
         assign sel_act = s.dead_time_ctrl_two[pwmfe_pkg::DT2_ACT_LSB + g];
         assign sel_inact =
            s.dead_time_ctrl_two[pwmfe_pkg::DT2_INACT_LSB + g];
         pwmfe_dead_time u_dt
         (
            .pclk(pclk),
            .presetn(presetn),
            .cmp(s.cmp[g]),
            .indep(s.pair_mode_sel[g]),
            .act_ps(sel_act ? ps_b : ps_a),
            .act_cnt(sel_act ? cnt_b : cnt_a),
            .inact_ps(sel_inact ? ps_b : ps_a),
            .inact_cnt(sel_inact ? cnt_b : cnt_a),
            .high_side_out(high_side_out[g]),
            .low_side_out(low_side_out[g])
         );
      end
   endgenerate

   assign prdata = s.rdata;
   assign time_base_count = s.count;
   assign count_direction = s.dir;
endmodule

// ==== pwmfe_pkg.sv ====
// Purpose: Shared constants of the fine-edge PWM and dead-time block.
// Assumes: pclk at 50 MHz; one instruction cycle spans two pclk cycles.
// Notes: Register offsets are byte addresses on a 32-bit APB bus.
package pwmfe_pkg;
   localparam int PAIRS = 4;
   localparam int CLK_NS = 20;
   localparam int TCY_NS = 40;
   localparam int TCY_PCLK = TCY_NS / CLK_NS;
   ////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PERIOD = 8'h04;
   localparam logic [7:0] ADDR_DUTY0 = 8'h08;
   localparam logic [7:0] ADDR_DT_ONE = 8'h18;
   localparam logic [7:0] ADDR_DT_TWO = 8'h1C;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   ////////////////////////////////////////////////////////////////////////
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_CENTER_BIT = 1;
   localparam int CTRL_TBPS_LSB = 4;
   localparam int CTRL_PAIR_MODE_SEL_LSB = 8;
   localparam int DT1_A_PS_LSB = 14;
   localparam int DT1_A_CNT_LSB = 8;
   localparam int DT1_B_PS_LSB = 6;
   localparam int DT1_B_CNT_LSB = 0;
   localparam int DT2_ACT_LSB = 0;
   localparam int DT2_INACT_LSB = 4;
   localparam int ST_DIR_BIT = 15;
   localparam int ST_HIGH_LSB = 16;
   localparam int ST_LOW_LSB = 20;
   ////////////////////////////////////////////////////////////////////////
   localparam logic [1:0] TBPS_1 = 2'h0;
   localparam logic [1:0] TBPS_4 = 2'h1;
   localparam logic [1:0] TBPS_16 = 2'h2;
   localparam logic [5:0] PRESC_MAX_4 = 6'h03;
   localparam logic [5:0] PRESC_MAX_16 = 6'h0F;
   localparam logic [5:0] PRESC_MAX_64 = 6'h3F;
   localparam logic [15:0] DUTY_RST = 16'h0000;
   localparam logic [14:0] PERIOD_RST = 15'h0000;
   localparam logic [15:0] DT1_RST = 16'h0000;
   localparam logic [7:0] DT2_RST = 8'h00;
   localparam logic [3:0] PAIR_MODE_SEL_RST = 4'h0;
endpackage

// ==== pwmfe_dead_time.sv ====
// Purpose: Dead-time insertion for one complementary output pair.
// Assumes: Edge unit values are chosen by the caller from units A and B.
// Notes: A new edge during a count restarts it, swallowing short pulses.
`timescale 1ns/1ps
module pwmfe_dead_time
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cmp,
   input wire logic indep,
   input wire logic [1:0] act_ps,
   input wire logic [5:0] act_cnt,
   input wire logic [1:0] inact_ps,
   input wire logic [5:0] inact_cnt,
   output logic high_side_out,
   output logic low_side_out
);
   typedef struct packed {
      logic cmp_q;
      logic indep_q;
      logic high;
      logic low;
      logic pend_h;
      logic pend_l;
      logic [5:0] cnt;
      logic [3:0] pre;
      logic [3:0] pre_last;
   } pwmfe_dt_type;

   pwmfe_dt_type s;
   pwmfe_dt_type next_s;
   logic rise;
   logic fall;

   // One dead-time clock lasts 1, 2, 4 or 8 instruction cycles.
   function automatic logic [3:0] tick_last(input logic [1:0] ps);
      tick_last = 4'(pwmfe_pkg::TCY_PCLK * (1 << ps) - 1);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Leaving independent mode counts as an edge, so that the idle side
   // only goes active after a full dead time.
   assign rise = cmp && (!s.cmp_q || s.indep_q);
   assign fall = !cmp && (s.cmp_q || s.indep_q);

   always_comb
   begin
      next_s = s;
      next_s.cmp_q = cmp;
      next_s.indep_q = indep;
      if (indep)
      begin
         next_s.high = cmp;
         next_s.low = cmp;
         next_s.pend_h = 1'b0;
         next_s.pend_l = 1'b0;
         next_s.cnt = 6'h00;
      end
      else if (rise)
      begin
         next_s.low = 1'b0;
         next_s.pend_l = 1'b0;
         next_s.pre = 4'h0;
         next_s.pre_last = tick_last(act_ps);
         next_s.cnt = act_cnt;
         next_s.high = (act_cnt == 6'h00);
         next_s.pend_h = (act_cnt != 6'h00);
      end
      else if (fall)
      begin
         next_s.high = 1'b0;
         next_s.pend_h = 1'b0;
         next_s.pre = 4'h0;
         next_s.pre_last = tick_last(inact_ps);
         next_s.cnt = inact_cnt;
         next_s.low = (inact_cnt == 6'h00);
         next_s.pend_l = (inact_cnt != 6'h00);
      end
      else if (s.pend_h || s.pend_l)
      begin
         if (s.pre == s.pre_last)
         begin
            next_s.pre = 4'h0;
            next_s.cnt = s.cnt - 6'h01;
            if (s.cnt == 6'h01)
            begin
               next_s.high = s.pend_h;
               next_s.low = s.pend_l;
               next_s.pend_h = 1'b0;
               next_s.pend_l = 1'b0;
            end
         end
         else
         begin
            next_s.pre = s.pre + 4'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '{cmp_q: 1'b0, indep_q: 1'b1, high: 1'b0, low: 1'b0,
                pend_h: 1'b0, pend_l: 1'b0, cnt: 6'h00, pre: 4'h0,
                pre_last: 4'h0};
      end
      else
      begin
         s <= next_s;
      end
   end

   assign high_side_out = s.high;
   assign low_side_out = s.low;
endmodule

// ==== pwmfe_chk.sv ====
// Purpose: Port checker of pwmfe_top.
// Assumes: Register writes are decoded here as the APB slave takes them.
// Notes: Delay checks watch pair 0 once the setup has been quiet a while.
`timescale 1ns/1ps
module pwmfe_chk
#(
   parameter int ADDR_W = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [pwmfe_pkg::PAIRS-1:0] high_side_out,
   input wire logic [pwmfe_pkg::PAIRS-1:0] low_side_out,
   input wire logic [14:0] time_base_count,
   input wire logic count_direction
);
   logic [15:0] ctl, per, dut, dt1;
   logic [7:0] dt2, age;
   logic [10:0] gl, gh, ea, ei;
   logic wr, q;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   function automatic logic [10:0] dly(input logic [7:0] u);
      return (11'(u[5:0]) << 1) << u[7:6];
   endfunction
   assign wr = psel & penable & pwrite & pready;
   // A write in flight may change a count, so delays are judged when quiet.
   assign q = age == 8'hFF;
   assign ea = dly(dt2[0] ? dt1[7:0] : dt1[15:8]);
   assign ei = dly(dt2[4] ? dt1[7:0] : dt1[15:8]);
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl <= 16'h0000;
         per <= 16'h0000;
         dut <= 16'h0000;
         dt1 <= 16'h0000;
         dt2 <= 8'h00;
         age <= 8'h00;
         gl <= 11'h000;
         gh <= 11'h000;
      end
      else
      begin
         age <= wr ? 8'h00 : age + 8'(age != 8'hFF);
         gl <= low_side_out[0] ? 11'h000 : gl + 11'(gl != 11'h7FF);
         gh <= high_side_out[0] ? 11'h000 : gh + 11'(gh != 11'h7FF);
         if (wr && paddr[7:0] == pwmfe_pkg::ADDR_CTRL)
            ctl <= pwdata[15:0];
         if (wr && paddr[7:0] == pwmfe_pkg::ADDR_PERIOD)
            per <= pwdata[15:0];
         if (wr && paddr[7:0] == pwmfe_pkg::ADDR_DUTY0)
            dut <= pwdata[15:0];
         if (wr && paddr[7:0] == pwmfe_pkg::ADDR_DT_ONE)
            dt1 <= pwdata[15:0];
         if (wr && paddr[7:0] == pwmfe_pkg::ADDR_DT_TWO)
            dt2 <= pwdata[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_comp_excl;
      age > 8'h03 |-> (high_side_out & low_side_out & ~ctl[11:8]) == 4'h0;
   endproperty
   a_comp_excl: assert property (p_comp_excl)
      else $error("complementary pair outputs overlap");
   property p_indep;
      age > 8'h03 |-> ((high_side_out ^ low_side_out) & ctl[11:8]) == 4'h0;
   endproperty
   a_indep: assert property (p_indep)
      else $error("independent pair outputs differ");
   property p_tb_step;
      q && ctl[5:4] == 2'h0 && $changed(time_base_count)
         |=> $stable(time_base_count) ##1 $changed(time_base_count);
   endproperty
   a_tb_step: assert property (p_tb_step)
      else $error("time base not stepping every two cycles");
   property p_dir_top;
      q && $rose(count_direction) |-> time_base_count == per[14:0]
         || $past(time_base_count) == per[14:0];
   endproperty
   a_dir_top: assert property (p_dir_top)
      else $error("count turned down away from period");
   property p_rise_hi;
      q && !ctl[8] && $rose(high_side_out[0]) |-> gl == ea;
   endproperty
   a_rise_hi: assert property (p_rise_hi)
      else $error("high side dead time wrong");
   property p_rise_lo;
      q && !ctl[8] && $rose(low_side_out[0]) |-> gh == ei;
   endproperty
   a_rise_lo: assert property (p_rise_lo)
      else $error("low side dead time wrong");
   property p_zero_duty;
      q && !ctl[8] && dut == 16'h0000 |-> !high_side_out[0];
   endproperty
   a_zero_duty: assert property (p_zero_duty)
      else $error("zero duty drives high side");
   property p_full_duty;
      q && !ctl[8] && ctl[0] && !ctl[1] && dut[15:1] > per[14:0]
         |-> !low_side_out[0];
   endproperty
   a_full_duty: assert property (p_full_duty)
      else $error("full duty drives low side");
endmodule

// ==== pwmfe_gate_model.sv ====
// Purpose: Gate driver load on the four output pairs.
// Assumes: Drive requests are active high.
// Notes: A real bridge leg shorts on overlap, so overlaps on the pairs set in comp_mask are counted.
`timescale 1ns/1ps
module pwmfe_gate_model
(
   input wire logic pclk,
   input wire logic [3:0] high_in,
   input wire logic [3:0] low_in,
   input wire logic [3:0] comp_mask,
   output int shorts
);
   int overlaps = 0;
   always @(posedge pclk)
   begin
      if ((high_in & low_in & comp_mask) != 4'h0)
         overlaps <= overlaps + 1;
   end
   assign shorts = overlaps;
endmodule

// ==== pwm_fine_edge_and_dead_time_test.sv ====
// Purpose: Self-checking bench of the fine-edge PWM block.
// Assumes: APB slave with no wait states; Tcy is two pclk cycles.
// Notes: Widths are summed over whole periods, so phase does not matter.
`timescale 1ns/1ps
module pwm_fine_edge_and_dead_time_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, count_direction, er;
   logic [3:0] high_side_out, low_side_out;
   logic [3:0] comp_mask = 4'hF;
   logic [14:0] time_base_count;
   int shorts, hs, ls, dr, f, da;
   int err_total = 0;
   int samples_checked = 0;
   always #10 pclk = ~pclk;
   pwmfe_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .high_side_out(high_side_out), .low_side_out(low_side_out),
      .time_base_count(time_base_count), .count_direction(count_direction));
   pwmfe_gate_model load (.pclk(pclk), .high_in(high_side_out),
      .low_in(low_side_out), .comp_mask(comp_mask), .shorts(shorts));
   ////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD t=%0t mismatch got %0h exp %0h", $time, g, e);
      end
   endtask
   // Counts over n cycles; a whole number of periods gives fixed sums.
   task automatic meas(input int p, input int n);
      logic pd;
      hs = 0;
      ls = 0;
      dr = 0;
      pd = count_direction;
      repeat (n)
      begin
         @(negedge pclk);
         hs += int'(high_side_out[p] === 1'b1);
         ls += int'(low_side_out[p] === 1'b1);
         dr += int'(count_direction === 1'b1 && pd === 1'b0);
         pd = count_direction;
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #1000000;
      err_total++;
      print_verdict;
   end
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(negedge pclk);
      chk(low_side_out, 4'hF);
      apb(1'b0, pwmfe_pkg::ADDR_DT_ONE, 0);
      chk(rd, 0);
      wr(pwmfe_pkg::ADDR_DUTY0, 32'h0000A5A5);
      apb(1'b0, pwmfe_pkg::ADDR_DUTY0, 0);
      chk(rd, 32'h0000A5A5);
      apb(1'b0, 8'h24, 0);
      chk(er, 1);
      chk(rd, 0);
      $display("test registers done");
      wr(pwmfe_pkg::ADDR_PERIOD, 9);
      wr(pwmfe_pkg::ADDR_CTRL, 1);
      for (int d = 1; d <= 20; d++)
      begin
         wr(pwmfe_pkg::ADDR_DUTY0, d);
         repeat (40) @(posedge pclk);
         meas(0, 20);
         chk(hs, d);
         chk(ls, 20 - d);
      end
      chk(dr, 0);
      $display("test half cycle edges done");
      for (int c = 1; c <= 3; c++)
      begin
         f = 4 ** c;
         wr(pwmfe_pkg::ADDR_CTRL, (c << 4) | 1);
         wr(pwmfe_pkg::ADDR_PERIOD, 2);
         wr(pwmfe_pkg::ADDR_DUTY0, 5);
         repeat (12 * f) @(posedge pclk);
         meas(0, 6 * f);
         chk(hs, 5 * f);
         chk(ls, f);
      end
      $display("test prescaled edges done");
      wr(pwmfe_pkg::ADDR_CTRL, 1);
      wr(pwmfe_pkg::ADDR_PERIOD, 149);
      for (int p = 0; p < 4; p++)
         wr(pwmfe_pkg::ADDR_DUTY0 + 4 * p, 150);
      wr(pwmfe_pkg::ADDR_DT_TWO, 32'h5A);
      for (int s = 0; s < 4; s++)
      begin
         wr(pwmfe_pkg::ADDR_DT_ONE, (s << 14) | 32'h0305);
         repeat (300) @(posedge pclk);
         da = 6 << s;
         for (int p = 0; p < 4; p++)
         begin
            meas(p, 300);
            chk(hs, 150 - (p % 2 ? 10 : da));
            chk(ls, 150 - (p % 2 ? da : 10));
         end
      end
      $display("test dead time done");
      wr(pwmfe_pkg::ADDR_DT_TWO, 0);
      wr(pwmfe_pkg::ADDR_DT_ONE, 32'h0500);
      for (int d = 10; d <= 11; d++)
      begin
         wr(pwmfe_pkg::ADDR_DUTY0 + 4, d);
         repeat (300) @(posedge pclk);
         meas(1, 300);
         chk(hs, d - 10);
         chk(ls, 290 - d);
      end
      for (int k = 0; k < 2; k++)
      begin
         wr(pwmfe_pkg::ADDR_DUTY0, k ? 32'hFFFF : 0);
         repeat (300) @(posedge pclk);
         meas(0, 300);
         chk(hs, 300 * k);
         chk(ls, 300 - 300 * k);
      end
      $display("test short and extreme duty done");
      comp_mask <= 4'h0;
      wr(pwmfe_pkg::ADDR_CTRL, 32'h0F01);
      repeat (20) @(posedge pclk);
      meas(2, 300);
      chk(hs, 150);
      chk(ls, 150);
      wr(pwmfe_pkg::ADDR_CTRL, 1);
      repeat (20) @(posedge pclk);
      comp_mask <= 4'hF;
      $display("test independent mode done");
      wr(pwmfe_pkg::ADDR_DT_ONE, 0);
      wr(pwmfe_pkg::ADDR_PERIOD, 9);
      wr(pwmfe_pkg::ADDR_DUTY0, 8);
      wr(pwmfe_pkg::ADDR_CTRL, 3);
      repeat (300) @(posedge pclk);
      meas(0, 360);
      chk(dr, 10);
      chk(hs, 160);
      chk(shorts, 0);
      $display("test center aligned done");
      print_verdict;
   end
endmodule
bind pwmfe_top pwmfe_chk #(.ADDR_W(ADDR_W)) chk_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .high_side_out(high_side_out),
   .low_side_out(low_side_out), .time_base_count(time_base_count),
   .count_direction(count_direction));
